// >>> verilog/byte_io_port_pkg.sv
// Package with register map, modes and carrier types for the byte I/O port
package byte_io_port_pkg;
  localparam int unsigned PORT_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 16;

  localparam logic [15:0] PULLUP_CONTROL_OFFSET   = 16'hffac;
  localparam logic [15:0] PIN_DIRECTION_OFFSET    = 16'hffb0;
  localparam logic [15:0] PIN_OUTPUT_LATCH_OFFSET = 16'hffb2;

  localparam logic [7:0] PULLUP_CONTROL_RESET      = 8'h00;
  localparam logic [7:0] PIN_DIRECTION_RESET       = 8'h00;
  localparam logic [7:0] PIN_DIRECTION_MODE1_VALUE = 8'hff;
  localparam logic [7:0] PIN_DIRECTION_READ_VALUE  = 8'hff;
  localparam logic [7:0] PIN_OUTPUT_LATCH_RESET    = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE       = 8'h00;

  // Operating mode as presented on the two mode pins
  localparam logic [1:0] MODE_CODE_1 = 2'h1;
  localparam logic [1:0] MODE_CODE_2 = 2'h2;
  localparam logic [1:0] MODE_CODE_3 = 2'h3;

  typedef enum logic [1:0] {
    MODE_EXPANDED_NO_ROM,
    MODE_EXPANDED_ROM,
    MODE_SINGLE_CHIP
  } chip_mode_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  typedef struct packed {
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
    logic [7:0] pullup_en;
  } pin_drive_s;
endpackage : byte_io_port_pkg

// >>> verilog/mode_aware_byte_io_port.sv
// Mode-aware 8-bit bidirectional I/O port with direction, latch and pull-up registers
//
// Overview of operation
// - Eight two-way pins, each with its own direction, latch and pull-up bit.
// - Mode 1: direction held all ones, writes ignored, reads give all ones.
// - Mode 1 hardware standby: address pins float.
// - Mode 2: direction one drives address bit, zero is general input.
// - Mode 3: direction one drives latch bit, zero is general input.
// - Modes 2 and 3: direction register write-only, reads all ones.
// - Direction resets to zeros (modes 2,3) or ones (mode 1); hardware standby clears.
// - Software standby keeps direction, so outputs keep driving.
// - Output latch is 8-bit read/write, bit n for pin n.
// - Port read of an output bit returns latch, not pin.
// - Port read of an input bit returns sampled pin level.
// - Latch cleared by reset and hardware standby, kept in software standby.
// - Pull-up on only when direction zero and pull-up bit one.
// - Pull-up register 8-bit read/write, cleared by reset and hardware standby.
// - Pull-ups usable only in modes 2 and 3, always off in mode 1.
// - Mode 1 expanded without ROM, mode 2 expanded with ROM, mode 3 single chip.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module mode_aware_byte_io_port #(
  parameter int unsigned WIDTH = byte_io_port_pkg::PORT_WIDTH
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_sys_rst,
  input  wire logic [1:0]           i_mode_pins,
  input  wire logic                 i_hw_standby,
  input  wire logic                 i_sw_standby,
  input  wire logic [WIDTH-1:0]     i_lower_address_lines,
  input  wire logic [15:0]          i_reg_addr,
  input  wire logic [7:0]           i_reg_wdata,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  output logic      [7:0]           o_reg_rdata,
  input  wire logic [WIDTH-1:0]     i_pin,
  output logic      [WIDTH-1:0]     o_pin,
  output logic      [WIDTH-1:0]     o_pin_oe_n,
  output logic      [WIDTH-1:0]     o_pullup_en
);

  byte_io_port_pkg::reg_req_s   req;
  byte_io_port_pkg::pin_drive_s next_drive;
  byte_io_port_pkg::chip_mode_e mode;
  logic [1:0]       mode_sync1;
  logic [1:0]       mode_sync2;
  logic [1:0]       hws_sync;
  logic             hw_standby;
  logic             hw_standby_q;
  logic [1:0]       strap_cnt;
  logic [WIDTH-1:0] pin_sync1;
  logic [WIDTH-1:0] pin_sync2;
  logic [WIDTH-1:0] pin_direction;
  logic [WIDTH-1:0] pin_output_latch;
  logic [WIDTH-1:0] pullup_control;
  logic [WIDTH-1:0] eff_direction;
  logic [WIDTH-1:0] port_read;
  logic             mode1;
  logic             standby_entry;

  assign req = '{addr: i_reg_addr, wdata: i_reg_wdata, wr: i_reg_wr, rd: i_reg_rd};

  // Mode and pins are board levels, so they pass two flops first
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_sync1 <= byte_io_port_pkg::MODE_CODE_3;
      mode_sync2 <= byte_io_port_pkg::MODE_CODE_3;
      hws_sync   <= 2'h0;
      pin_sync1  <= '0;
      pin_sync2  <= '0;
    end else begin
      mode_sync1 <= i_mode_pins;
      mode_sync2 <= mode_sync1;
      hws_sync   <= {hws_sync[0], i_hw_standby};
      pin_sync1  <= i_pin;
      pin_sync2  <= pin_sync1;
    end
  end

  assign hw_standby = hws_sync[1];

  // Mode is latched once, at the third edge after release, when the strap has crossed both flops
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      strap_cnt <= 2'h0;
    end else if (strap_cnt != 2'h3) begin
      strap_cnt <= strap_cnt + 2'h1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode <= byte_io_port_pkg::MODE_SINGLE_CHIP;
    end else if (strap_cnt == 2'h2) begin
      unique case (mode_sync2)
        byte_io_port_pkg::MODE_CODE_1: mode <= byte_io_port_pkg::MODE_EXPANDED_NO_ROM;
        byte_io_port_pkg::MODE_CODE_2: mode <= byte_io_port_pkg::MODE_EXPANDED_ROM;
        default:                       mode <= byte_io_port_pkg::MODE_SINGLE_CHIP;
      endcase
    end
  end

  assign mode1 = (mode == byte_io_port_pkg::MODE_EXPANDED_NO_ROM);

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hw_standby_q <= 1'b0;
    end else begin
      hw_standby_q <= hw_standby;
    end
  end

  assign standby_entry = hw_standby & ~hw_standby_q;

  // Software standby needs no term: registers simply hold
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_direction <= byte_io_port_pkg::PIN_DIRECTION_RESET;
    end else if (hw_standby) begin
      pin_direction <= byte_io_port_pkg::PIN_DIRECTION_RESET;
    end else if (req.wr && req.addr == byte_io_port_pkg::PIN_DIRECTION_OFFSET && !mode1) begin
      pin_direction <= req.wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_output_latch <= byte_io_port_pkg::PIN_OUTPUT_LATCH_RESET;
    end else if (hw_standby) begin
      pin_output_latch <= byte_io_port_pkg::PIN_OUTPUT_LATCH_RESET;
    end else if (req.wr && req.addr == byte_io_port_pkg::PIN_OUTPUT_LATCH_OFFSET) begin
      pin_output_latch <= req.wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pullup_control <= byte_io_port_pkg::PULLUP_CONTROL_RESET;
    end else if (hw_standby) begin
      pullup_control <= byte_io_port_pkg::PULLUP_CONTROL_RESET;
    end else if (req.wr && req.addr == byte_io_port_pkg::PULLUP_CONTROL_OFFSET) begin
      pullup_control <= req.wdata[WIDTH-1:0];
    end
  end

  // Mode 1 forces every bit to output, whatever is stored
  assign eff_direction = mode1 ? byte_io_port_pkg::PIN_DIRECTION_MODE1_VALUE[WIDTH-1:0]
                               : pin_direction;

  assign port_read = (eff_direction & pin_output_latch) | (~eff_direction & pin_sync2);

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= byte_io_port_pkg::UNMAPPED_READ_VALUE;
    end else if (req.rd) begin
      unique case (req.addr)
        byte_io_port_pkg::PIN_DIRECTION_OFFSET:
          o_reg_rdata <= byte_io_port_pkg::PIN_DIRECTION_READ_VALUE;
        byte_io_port_pkg::PIN_OUTPUT_LATCH_OFFSET:
          o_reg_rdata <= 8'(port_read);
        byte_io_port_pkg::PULLUP_CONTROL_OFFSET:
          o_reg_rdata <= 8'(pullup_control);
        default:
          o_reg_rdata <= byte_io_port_pkg::UNMAPPED_READ_VALUE;
      endcase
    end else begin
      o_reg_rdata <= byte_io_port_pkg::UNMAPPED_READ_VALUE;
    end
  end

  always_comb begin
    next_drive = '0;
    next_drive.pin_oe_n  = '1;
    next_drive.pin_out   = '0;
    next_drive.pullup_en = '0;
    for (int i = 0; i < WIDTH; i++) begin
      unique case (mode)
        byte_io_port_pkg::MODE_EXPANDED_NO_ROM: begin
          next_drive.pin_out[i]  = i_lower_address_lines[i];
          next_drive.pin_oe_n[i] = hw_standby;
        end
        byte_io_port_pkg::MODE_EXPANDED_ROM: begin
          next_drive.pin_out[i]  = eff_direction[i] & i_lower_address_lines[i];
          next_drive.pin_oe_n[i] = ~eff_direction[i];
          next_drive.pullup_en[i] = ~eff_direction[i] & pullup_control[i];
        end
        byte_io_port_pkg::MODE_SINGLE_CHIP: begin
          next_drive.pin_out[i]  = eff_direction[i] & pin_output_latch[i];
          next_drive.pin_oe_n[i] = ~eff_direction[i];
          next_drive.pullup_en[i] = ~eff_direction[i] & pullup_control[i];
        end
      endcase
    end
  end

  // Registered pin drive costs one cycle of latency on address output
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pin       <= '0;
      o_pin_oe_n  <= '1;
      o_pullup_en <= '0;
    end else begin
      o_pin       <= next_drive.pin_out;
      o_pin_oe_n  <= next_drive.pin_oe_n;
      o_pullup_en <= next_drive.pullup_en;
    end
  end

endmodule : mode_aware_byte_io_port

// >>> tb/mode_aware_byte_io_port_assertions.sv
// Checker tying the port's outputs to its strap, standby, bus and address inputs
`timescale 1ns/1ps
module byte_io_port_checker (
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic [1:0]  i_mode_pins,
  input wire logic        i_hw_standby,
  input wire logic [7:0]  i_lower_address_lines,
  input wire logic [15:0] i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic [7:0]  o_pin,
  input wire logic [7:0]  o_pin_oe_n,
  input wire logic [7:0]  o_pullup_en
);
  logic [3:0] calm;
  logic       settled;
  // Cycles clear of reset and standby; strap latch and syncs need several
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    if (i_sys_rst) calm <= 4'h0;
    else if (i_hw_standby) calm <= 4'h0;
    else if (calm != 4'hf) calm <= calm + 4'h1;
  assign settled = calm > 4'h7;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_rd(a); i_reg_rd && i_reg_addr == a; endsequence
  sequence s_pcr_wr; settled && i_mode_pins != 2'h1 && i_reg_wr && i_reg_addr == 16'hffac ##1 !i_reg_wr [*2]; endsequence
  property p_idle; !i_reg_rd |=> o_reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside its slot");
  property p_dir; s_rd(16'hffb0) |=> o_reg_rdata == 8'hff; endproperty
  a_dir: assert property (p_dir) else $error("direction read not all ones");
  property p_pu; (o_pullup_en & ~o_pin_oe_n) == 8'h00; endproperty
  a_pu: assert property (p_pu) else $error("pull-up on a driven pin");
  property p_hw; i_hw_standby [*5] |-> o_pin_oe_n == 8'hff && o_pullup_en == 8'h00; endproperty
  a_hw: assert property (p_hw) else $error("pins active in hardware standby");
  property p_m1; settled && i_mode_pins == 2'h1 |-> o_pin_oe_n == 8'h00 && o_pullup_en == 8'h00
    && o_pin == $past(i_lower_address_lines); endproperty
  a_m1: assert property (p_m1) else $error("mode 1 pins not address");
  property p_m2; settled && i_mode_pins == 2'h2 |-> ((o_pin ^ $past(i_lower_address_lines)) & ~o_pin_oe_n) == 8'h00; endproperty
  a_m2: assert property (p_m2) else $error("mode 2 output not address");
  property p_rdl; settled && i_mode_pins == 2'h3 && !i_reg_wr && !$past(i_reg_wr) ##0 s_rd(16'hffb2)
    |=> ((o_reg_rdata ^ o_pin) & ~o_pin_oe_n) == 8'h00; endproperty
  a_rdl: assert property (p_rdl) else $error("output bit read not latch");
  property p_pcr; s_pcr_wr |-> o_pullup_en == ($past(i_reg_wdata, 2) & o_pin_oe_n); endproperty
  a_pcr: assert property (p_pcr) else $error("pull-up not per control");
endmodule : byte_io_port_checker
bind mode_aware_byte_io_port byte_io_port_checker u_chk (.i_ref_clk, .i_sys_rst, .i_mode_pins, .i_hw_standby,
  .i_lower_address_lines, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_pin, .o_pin_oe_n,
  .o_pullup_en);

// >>> tb/pin_board_model.sv
// Board-side pin model: external drivers, pull-ups and floating pins
`timescale 1ns/1ps
module pin_board_model (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_drive,
  input  wire logic [7:0] i_drive_oe_n,
  input  wire logic [7:0] i_pullup_en,
  input  wire logic [7:0] i_ext_val,
  input  wire logic [7:0] i_ext_en,
  output logic      [7:0] o_level
);
  // Undriven pins toggle so a stale level never reads back by luck
  logic [7:0] float_q = 8'h5a;
  always @(posedge i_ref_clk) float_q <= ~o_level;
  always_comb
    for (int b = 0; b < 8; b++)
      o_level[b] = !i_drive_oe_n[b] ? i_drive[b] : i_ext_en[b] ? i_ext_val[b] : i_pullup_en[b] | float_q[b];
endmodule : pin_board_model

// >>> tb/mode_aware_byte_io_port_tb.sv
// Self-checking bench for the mode-aware byte I/O port
`timescale 1ns/1ps
module mode_aware_byte_io_port_tb;
  logic                         ref_clk = 1'b0, sys_rst = 1'b1, hw_sb = 1'b0, sw_sb = 1'b0;
  logic [1:0]                   mode    = 2'h3;
  logic [7:0]                   addr_lo = 8'h96, ext_en = 8'hff, rdata, pin_in;
  byte_io_port_pkg::reg_req_s   req     = '0;
  byte_io_port_pkg::pin_drive_s drv;
  int                           error_cnt = 0, n_tests = 0, cyc = 0;
  always #50 ref_clk = ~ref_clk;
  mode_aware_byte_io_port dut (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_mode_pins(mode), .i_hw_standby(hw_sb),
    .i_sw_standby(sw_sb), .i_lower_address_lines(addr_lo), .i_reg_addr(req.addr), .i_reg_wdata(req.wdata),
    .i_reg_wr(req.wr), .i_reg_rd(req.rd), .o_reg_rdata(rdata), .i_pin(pin_in), .o_pin(drv.pin_out),
    .o_pin_oe_n(drv.pin_oe_n), .o_pullup_en(drv.pullup_en));
  pin_board_model board (.i_ref_clk(ref_clk), .i_drive(drv.pin_out), .i_drive_oe_n(drv.pin_oe_n),
    .i_pullup_en(drv.pullup_en), .i_ext_val(8'h3c), .i_ext_en(ext_en), .o_level(pin_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk) req.wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge ref_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk) req.rd <= 1'b0;
    @(negedge ref_clk) chk(rdata, exp);
  endtask : rd_reg
  // Pin outputs trail the write by registered stages
  task automatic outs(input logic [7:0] oe, input logic [7:0] pin, input logic [7:0] pu);
    repeat (3) @(negedge ref_clk);
    chk(drv.pin_oe_n, oe);
    chk(drv.pin_out & ~oe, pin & ~oe);
    chk(drv.pullup_en, pu);
  endtask : outs
  task automatic do_reset(input logic [1:0] m);
    @(posedge ref_clk) sys_rst <= 1'b1;
    mode <= m;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask : do_reset
  task automatic t_mode3;
    do_reset(2'h3);
    outs(8'hff, 8'h00, 8'h00);
    rd_reg(16'hffac, 8'h00);
    rd_reg(16'hffb2, 8'h3c);
    wr_reg(16'hffb0, 8'h0f);
    wr_reg(16'hffb2, 8'ha5);
    wr_reg(16'hffac, 8'hff);
    ext_en <= 8'h00;
    outs(8'hf0, 8'ha5, 8'hf0);
    rd_reg(16'hffb2, 8'hf5);
    rd_reg(16'hffb0, 8'hff);
    wr_reg(16'hffae, 8'h77);
    rd_reg(16'hfffe, 8'h00);
    rd_reg(16'hffac, 8'hff);
  endtask : t_mode3
  task automatic t_standby;
    @(posedge ref_clk) sw_sb <= 1'b1;
    outs(8'hf0, 8'ha5, 8'hf0);
    @(posedge ref_clk) hw_sb <= 1'b1;
    ext_en <= 8'hff;
    repeat (3) @(posedge ref_clk);
    outs(8'hff, 8'h00, 8'h00);
    @(posedge ref_clk) hw_sb <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rd_reg(16'hffac, 8'h00);
    wr_reg(16'hffb0, 8'hff);
    rd_reg(16'hffb2, 8'h00);
    @(posedge ref_clk) sw_sb <= 1'b0;
  endtask : t_standby
  task automatic t_mode2;
    do_reset(2'h2);
    outs(8'hff, 8'h00, 8'h00);
    wr_reg(16'hffb0, 8'hf0);
    wr_reg(16'hffb2, 8'h0f);
    wr_reg(16'hffac, 8'hff);
    outs(8'h0f, 8'h96, 8'h0f);
    rd_reg(16'hffb2, 8'h0c);
    @(posedge ref_clk) addr_lo <= 8'h69;
    outs(8'h0f, 8'h69, 8'h0f);
  endtask : t_mode2
  task automatic t_mode1;
    do_reset(2'h1);
    wr_reg(16'hffb0, 8'h00);
    wr_reg(16'hffac, 8'hff);
    wr_reg(16'hffb2, 8'h3c);
    outs(8'h00, 8'h69, 8'h00);
    rd_reg(16'hffb0, 8'hff);
    rd_reg(16'hffb2, 8'h3c);
    rd_reg(16'hffac, 8'hff);
    @(posedge ref_clk) hw_sb <= 1'b1;
    repeat (3) @(posedge ref_clk);
    outs(8'hff, 8'h00, 8'h00);
  endtask : t_mode1
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    t_mode3;
    t_standby;
    t_mode2;
    t_mode1;
    print_verdict;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      print_verdict;
    end
  end
endmodule : mode_aware_byte_io_port_tb
